// ==== hw/slld_divider.sv ====
// Purpose: Programmable event divider giving one pulse per ratio input ticks.
// Assumes: Ratio is at least one; a new ratio is compared from the next tick, even in the middle of a period.
// Notes:   Used for both the reference counter and the feedback counter.
`default_nettype none

module slld_divider
   import slld_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             run,
   input  wire logic             tick,
   input  wire logic [INT_W-1:0] ratio,
   output var  logic             pulse
);

   logic [INT_W-1:0] count;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 12'h000;
         pulse <= 1'b0;
      end else if (!run) begin
         count <= 12'h000;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         if (tick) begin
            if (count >= ratio - 12'h001) begin
               count <= 12'h000;
               pulse <= 1'b1;
            end else begin
               count <= count + 12'h001;
            end
         end
      end
   end

   property p_pulse_cause;
      @(posedge mclk) disable iff (!reset_n)
      pulse |-> $past(tick) && $past(run);
   endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("divider pulse without tick"); // [RULE3]

endmodule : slld_divider

`default_nettype wire

// ==== hw/slld_pkg.sv ====
// Purpose: Shared constants and types for the serial latch loader and dividers.
// Assumes: One 100 MHz clock; serial pins are asynchronous to it.
// Notes:   Field positions refer to the 32-bit serial word, bit 0 first sent last.
`default_nettype none

package slld_pkg;

   localparam int WORD_W      = 32;
   localparam int NUM_LATCH   = 8;
   localparam int SEL_W       = 3;
   localparam int INT_W       = 12;
   localparam int FRACTION_NUMERATOR_W      = 25;
   localparam int FRACTION_NUMERATOR_LO_W   = 13;
   localparam int FRACTION_NUMERATOR_HI_W   = 12;
   localparam int RCNT_W      = 5;
   localparam int CUR_W       = 4;
   localparam int MUX_W       = 4;

   // Latch 0 fields.
   localparam int L0_MUX_LSB  = 27;
   localparam int L0_INT_LSB  = 15;
   localparam int L0_FHI_LSB  = 3;
   // Latch 1 fields.
   localparam int L1_FLO_LSB  = 15;
   // Latch 2 fields.
   localparam int L2_CUR_LSB  = 24;
   localparam int L2_HALF_BIT = 21;
   localparam int L2_DBL_BIT  = 20;
   localparam int L2_RCNT_LSB = 15;

   localparam logic [SEL_W-1:0] SEL_LATCH0 = 3'h0;
   localparam logic [SEL_W-1:0] SEL_LATCH1 = 3'h1;
   localparam logic [SEL_W-1:0] SEL_LATCH2 = 3'h2;

   localparam logic [INT_W-1:0]  INT_MIN      = 12'h017;
   localparam logic [INT_W-1:0]  R_ZERO_RATIO = 12'h020;
   localparam logic [WORD_W-1:0] LATCH_RESET  = 32'h0000_0000;

   // Observation output selections.
   localparam logic [MUX_W-1:0] OBS_LOW     = 4'h0;
   localparam logic [MUX_W-1:0] OBS_HIGH    = 4'h1;
   localparam logic [MUX_W-1:0] OBS_REFDIV  = 4'h2;
   localparam logic [MUX_W-1:0] OBS_FBDIV   = 4'h3;
   localparam logic [MUX_W-1:0] OBS_SERDATA = 4'h4;
   localparam logic [MUX_W-1:0] OBS_POWERED = 4'h5;

   // APB map.
   localparam logic [7:0] APB_CTRL    = 8'h00;
   localparam logic [7:0] APB_STATUS  = 8'h04;
   localparam logic [7:0] APB_INTFRAC = 8'h08;
   localparam logic [7:0] APB_REFCFG  = 8'h0C;
   localparam logic [7:0] APB_LATCH0  = 8'h20;
   localparam logic [7:0] APB_LATCH7  = 8'h3C;
   localparam logic [WORD_W-1:0] CTRL_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [MUX_W-1:0]  muxSel;
      logic [INT_W-1:0]  intVal;
      logic [FRACTION_NUMERATOR_W-1:0] fracVal;
      logic [RCNT_W-1:0] refCount;
      logic              doubler;
      logic              halver;
      logic [CUR_W-1:0]  current;
   } slld_cfg_s;

endpackage : slld_pkg

`default_nettype wire

// ==== hw/slld_top.sv ====
// Purpose: Serial latch loader with double-buffered divider settings.
// Assumes: Serial clock and load strobe are much slower than mclk.
// Notes:   APB gives readback of the latches and a software power-down.
//
// Summary of operation
// [RULE1] The feedback divider uses any 12-bit integer ratio from 23 to 4095.
// [RULE2] The fraction is a 25-bit numerator over two to the 25th added to the integer ratio; the code drops the carry at integer ratio 4095.
// [RULE3] The 5-bit reference counter divides the reference by 1 to 32.
// [RULE4] The doubler bit doubles the reference and the halver bit halves the counter output.
// [RULE5] Words are 32 bits MSB first, one bit shifted on each serial clock rising edge.
// [RULE6] A load strobe rising edge copies the shift register into the latch named by bits 2 to 0.
// [RULE7] The three select bits are a binary index with bit 2 most significant.
// [RULE8] Low fraction, reference count, doubler, current and halver wait in shadow until latch 0.
// [RULE9] The low fraction lives in latch 1 and the high fraction in latch 0.
// [RULE10] A four-bit field picks the signal driven on the observation output.
// [RULE11] A low chip enable powers down and turns off the charge pump drive.
// [RULE12] All shadowed settings become active together with the latch 0 update.
`default_nettype none

module slld_top
   import slld_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic              serClk,
   input  wire logic              serData,
   input  wire logic              load_strobe,
   input  wire logic              chipEnable,
   input  wire logic              refIn,
   input  wire logic              fbIn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [WORD_W-1:0] pwdata,
   output var  logic [WORD_W-1:0] prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   output var  logic              observation_output,
   output var  logic              cpEnable,
   output var  logic [CUR_W-1:0]  cpCurrent,
   output var  logic              pfdRefPulse,
   output var  logic              pfdFbPulse
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic [4:0] pinMeta;
   logic [4:0] pinSync;
   logic [4:0] pinLast;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta <= 5'h00;
         pinSync <= 5'h00;
         pinLast <= 5'h00;
      end else begin
         pinMeta <= {fbIn, refIn, chipEnable, load_strobe, serClk};
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   logic serRise;
   logic loadRise;
   logic ceSync;
   logic refRise;
   logic refFall;
   logic fbRise;
   logic dataMeta;
   logic dataSync;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dataMeta <= 1'b0;
         dataSync <= 1'b0;
      end else begin
         dataMeta <= serData;
         dataSync <= dataMeta;
      end
   end

   assign serRise  = pinSync[0] & ~pinLast[0];
   assign loadRise = pinSync[1] & ~pinLast[1];
   assign ceSync   = pinSync[2];
   assign refRise  = pinSync[3] & ~pinLast[3];
   assign refFall  = ~pinSync[3] & pinLast[3];
   assign fbRise   = pinSync[4] & ~pinLast[4];

   ////////////////////////////////////////////////////////////////////////////
   // Shift register and latches.

   logic [WORD_W-1:0] shiftReg;
   logic [WORD_W-1:0] latchWord [NUM_LATCH];
   logic [SEL_W-1:0]  loadSel;

   // Data is delayed by the same two stages as the clock edge, so it must be stable before the serial clock rises.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         shiftReg <= LATCH_RESET;
      end else if (serRise) begin
         shiftReg <= {shiftReg[WORD_W-2:0], dataSync}; // [RULE5]
      end
   end

   assign loadSel = shiftReg[SEL_W-1:0]; // [RULE7]

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LATCH; gi++) begin : g_latch
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               latchWord[gi] <= LATCH_RESET;
            end else if (loadRise && loadSel == SEL_W'(gi)) begin
               latchWord[gi] <= shiftReg; // [RULE6]
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Active configuration, refreshed only by a latch 0 load.

   slld_cfg_s cfg;
   slld_cfg_s next_cfg;
   logic      shadowPending;

   always_comb begin
      next_cfg          = cfg;
      next_cfg.muxSel   = shiftReg[L0_MUX_LSB +: MUX_W];
      next_cfg.intVal   = shiftReg[L0_INT_LSB +: INT_W];
      next_cfg.fracVal  = {shiftReg[L0_FHI_LSB +: FRACTION_NUMERATOR_HI_W],
                           latchWord[1][L1_FLO_LSB +: FRACTION_NUMERATOR_LO_W]}; // [RULE9]
      next_cfg.refCount = latchWord[2][L2_RCNT_LSB +: RCNT_W]; // [RULE8]
      next_cfg.doubler  = latchWord[2][L2_DBL_BIT];
      next_cfg.halver   = latchWord[2][L2_HALF_BIT];
      next_cfg.current  = latchWord[2][L2_CUR_LSB +: CUR_W];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cfg <= '0;
      end else if (loadRise && loadSel == SEL_LATCH0) begin
         cfg <= next_cfg; // [RULE12]
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         shadowPending <= 1'b0;
      end else if (loadRise && loadSel == SEL_LATCH0) begin
         shadowPending <= 1'b0;
      end else if (loadRise && (loadSel == SEL_LATCH1 || loadSel == SEL_LATCH2)) begin
         shadowPending <= 1'b1; // [RULE8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave with one wait state.

   logic [WORD_W-1:0] ctrlReg;
   logic              apbAccess;
   logic              running;

   assign apbAccess = psel & penable & ~pready;
   assign running   = ceSync & ~ctrlReg[0]; // [RULE11]

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         ctrlReg <= CTRL_RESET;
      end else begin
         pready  <= apbAccess;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (apbAccess) begin
            if (pwrite) begin
               if (paddr == APB_CTRL) begin
                  ctrlReg <= {31'h0000_0000, pwdata[0]};
               end else begin
                  pslverr <= 1'b1;
               end
            end else if (paddr == APB_CTRL) begin
               prdata <= ctrlReg;
            end else if (paddr == APB_STATUS) begin
               prdata <= {29'h0000_0000, shadowPending, running, ceSync};
            end else if (paddr == APB_INTFRAC) begin
               prdata <= {cfg.intVal[6:0], cfg.fracVal};
            end else if (paddr == APB_REFCFG) begin
               prdata <= {16'h0000, cfg.muxSel, cfg.current, cfg.halver, cfg.doubler, 1'b0, cfg.refCount};
            end else if (paddr >= APB_LATCH0 && paddr <= APB_LATCH7 && paddr[1:0] == 2'h0) begin
               prdata <= latchWord[paddr[4:2]];
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference path: doubler, counter and halver.

   logic [INT_W-1:0] rRatio;
   logic             refTick;
   logic             rPulse;
   logic             halfPhase;

   assign refTick = cfg.doubler ? (refRise | refFall) : refRise; // [RULE4]
   assign rRatio  = (cfg.refCount == 5'h00) ? R_ZERO_RATIO : {7'h00, cfg.refCount}; // [RULE3]

   slld_divider u_refDiv (
      .mclk    (mclk),
      .reset_n (reset_n),
      .run     (running),
      .tick    (refTick),
      .ratio   (rRatio),
      .pulse   (rPulse)
   );

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         halfPhase   <= 1'b0;
         pfdRefPulse <= 1'b0;
      end else begin
         if (rPulse) begin
            halfPhase <= ~halfPhase;
         end
         pfdRefPulse <= rPulse & (~cfg.halver | halfPhase); // [RULE4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feedback path: integer divider steered by a fraction accumulator.

   logic [INT_W-1:0]  intUsed;
   logic [INT_W-1:0]  nRatio;
   logic [FRACTION_NUMERATOR_W-1:0] fracAcc;
   logic [FRACTION_NUMERATOR_W:0]   fracSum;
   logic              fracCarry;
   logic              nPulse;

   assign intUsed = (cfg.intVal < INT_MIN) ? INT_MIN : cfg.intVal; // [RULE1]
   assign nRatio  = fracCarry ? intUsed + 12'h001 : intUsed;
   assign fracSum = {1'b0, fracAcc} + {1'b0, cfg.fracVal};

   // Carry past 4095 would wrap, so the extra cycle is dropped at the top ratio.
   slld_divider u_fbDiv (
      .mclk    (mclk),
      .reset_n (reset_n),
      .run     (running),
      .tick    (fbRise),
      .ratio   ((fracCarry && intUsed != 12'hFFF) ? nRatio : intUsed),
      .pulse   (nPulse)
   );

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fracAcc    <= 25'h000_0000;
         fracCarry  <= 1'b0;
         pfdFbPulse <= 1'b0;
      end else begin
         pfdFbPulse <= nPulse;
         if (nPulse) begin
            fracAcc   <= fracSum[FRACTION_NUMERATOR_W-1:0]; // [RULE2]
            fracCarry <= fracSum[FRACTION_NUMERATOR_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Observation output and charge pump control.

   function automatic logic slld_obs(input logic [MUX_W-1:0] sel, input logic refSig,
                                     input logic fbSig, input logic dataSig, input logic pwrSig);
      logic val;
      val = 1'b0;
      case (sel)
         OBS_LOW:     val = 1'b0;
         OBS_HIGH:    val = 1'b1;
         OBS_REFDIV:  val = refSig;
         OBS_FBDIV:   val = fbSig;
         OBS_SERDATA: val = dataSig;
         OBS_POWERED: val = pwrSig;
         default:     val = 1'b0;
      endcase
      return val;
   endfunction : slld_obs

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         observation_output <= 1'b0;
         cpEnable           <= 1'b0;
         cpCurrent          <= 4'h0;
      end else begin
         observation_output <= slld_obs(cfg.muxSel, rPulse, nPulse, shiftReg[WORD_W-1], running); // [RULE10]
         cpEnable           <= running; // [RULE11]
         cpCurrent          <= cfg.current;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_shift_in;
      serRise |=> shiftReg[0] == $past(dataSync) && shiftReg[WORD_W-1:1] == $past(shiftReg[WORD_W-2:0]);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in"); // [RULE5]

   property p_latch_load;
      loadRise |=> latchWord[$past(loadSel)] == $past(shiftReg);
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("latch not loaded"); // [RULE6]

   property p_latch_index;
      loadRise && loadSel == 3'h5 |=> latchWord[4] == $past(latchWord[4]) && latchWord[6] == $past(latchWord[6]);
   endproperty
   a_latch_index: assert property (p_latch_index) else $error("wrong latch written"); // [RULE7]

   property p_shadow_hold;
      !(loadRise && loadSel == SEL_LATCH0) |=> $stable(cfg);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("active settings changed without latch 0"); // [RULE8]

   property p_apply_together;
      loadRise && loadSel == SEL_LATCH0 |=>
         cfg.fracVal[FRACTION_NUMERATOR_LO_W-1:0] == $past(latchWord[1][L1_FLO_LSB +: FRACTION_NUMERATOR_LO_W]) &&
         cfg.refCount == $past(latchWord[2][L2_RCNT_LSB +: RCNT_W]) &&
         cfg.intVal == $past(shiftReg[L0_INT_LSB +: INT_W]);
   endproperty
   a_apply_together: assert property (p_apply_together) else $error("settings not applied together"); // [RULE12]

   property p_int_range;
      intUsed >= INT_MIN && (cfg.intVal < INT_MIN || intUsed == cfg.intVal);
   endproperty
   a_int_range: assert property (p_int_range) else $error("integer ratio out of range"); // [RULE1]

   property p_r_range;
      rRatio >= 12'h001 && rRatio <= R_ZERO_RATIO;
   endproperty
   a_r_range: assert property (p_r_range) else $error("reference ratio out of range"); // [RULE3]

   property p_power_down;
      !ceSync |=> !cpEnable ##1 !cpEnable || ceSync;
   endproperty
   a_power_down: assert property (p_power_down) else $error("charge pump on while disabled"); // [RULE11]

   property p_obs_mux;
      cfg.muxSel == OBS_HIGH && $stable(cfg.muxSel) |=> observation_output;
   endproperty
   a_obs_mux: assert property (p_obs_mux) else $error("observation output not high"); // [RULE10]

   property p_fraction_numerator_step;
      nPulse |=> fracAcc == $past(fracSum[FRACTION_NUMERATOR_W-1:0]) && fracCarry == $past(fracSum[FRACTION_NUMERATOR_W]);
   endproperty
   a_fraction_numerator_step: assert property (p_fraction_numerator_step) else $error("fraction accumulator wrong"); // [RULE2]

   property p_halver;
      cfg.halver && $stable(cfg.halver) && rPulse && !halfPhase |=> !pfdRefPulse;
   endproperty
   a_halver: assert property (p_halver) else $error("halver let pulse through"); // [RULE4]

endmodule : slld_top

`default_nettype wire

// ==== sim/slld_host_model.sv ====
// Purpose: Host side of the three-wire serial load interface.
// Assumes: Serial clock high and low times of at least 3 mclk cycles.
// Notes:   The serial clock stands low between frames; data shows the inverse of the last bit.
`default_nettype none

module slld_host_model
   import slld_pkg::*;
(
   input  wire logic mclk,
   output var  logic serClk,
   output var  logic serData,
   output var  logic load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      serClk      = 1'b0;
      serData     = 1'b0;
      load_strobe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One whole word, most significant bit first, then a load strobe pulse.
   task automatic send(input logic [WORD_W-1:0] word);
      for (int i = WORD_W-1; i >= 0; i--) begin
         @(posedge mclk) serData <= word[i];
         repeat (2) @(posedge mclk);
         serClk <= 1'b1;
         repeat (4) @(posedge mclk);
         serClk <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      serData     <= ~word[0];
      load_strobe <= 1'b1;
      repeat (5) @(posedge mclk);
      load_strobe <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : send
endmodule : slld_host_model

`default_nettype wire

// ==== sim/slld_tb.sv ====
// Purpose: Self-checking bench for the serial latch loader and dividers.
// Assumes: APB reads are scored by a monitor that pops expected notes from a queue.
// Notes:   Divider periods are measured between consecutive output pulses.
`default_nettype none

module tb
   import slld_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              mclk = 1'b0, reset_n = 1'b0, chipEnable = 1'b1, refIn = 1'b0, fbIn = 1'b0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [WORD_W-1:0] pwdata = 32'h0000_0000, prdata, w[NUM_LATCH];
   logic              pready, pslverr, observation_output, cpEnable, pfdRefPulse, pfdFbPulse;
   logic              serClk, serData, load_strobe;
   logic [CUR_W-1:0]  cpCurrent;
   logic [64:0]       notes[$];
   int                n_errors = 0, n_checks = 0, ph = 0;

   slld_top i_dut (.mclk(mclk), .reset_n(reset_n), .serClk(serClk), .serData(serData),
      .load_strobe(load_strobe), .chipEnable(chipEnable), .refIn(refIn), .fbIn(fbIn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .observation_output(observation_output),
      .cpEnable(cpEnable), .cpCurrent(cpCurrent), .pfdRefPulse(pfdRefPulse), .pfdFbPulse(pfdFbPulse));
   slld_host_model i_host (.mclk(mclk), .serClk(serClk), .serData(serData), .load_strobe(load_strobe));

   initial forever #5 mclk = ~mclk;

   // Reference edges every 4 cycles, feedback edges every 2 cycles.
   always @(posedge mclk) begin
      ph <= ph + 1;
      if (ph % 4 == 3) refIn <= ~refIn;
      if (ph % 2 == 1) fbIn <= ~fbIn;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] s, input logic [63:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check

   task automatic summarize();
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] e, input logic err);
      int n;
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      notes.push_back({err, m, e});
      @(posedge mclk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   always @(posedge mclk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) check(64'h1, 64'h0);
         else check({pslverr, prdata & notes[0][63:32]}, {notes[0][64], notes[0][31:0]});
         if (notes.size() > 0) void'(notes.pop_front());
      end
   end

   task automatic shadow(input logic [3:0] cur, input logic [4:0] r, input logic d, input logic h,
                         input logic [12:0] flo);
      i_host.send({4'h0, flo, 15'h0001});
      i_host.send({4'h0, cur, 2'b00, h, d, r, 15'h0002});
   endtask : shadow

   task automatic gap(input logic fb, input int e);
      int n;
      n = 0;
      repeat (2) do begin
         @(posedge mclk);
         n++;
      end while ((fb ? pfdFbPulse : pfdRefPulse) !== 1'b1 && n < 3000);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((fb ? pfdFbPulse : pfdRefPulse) !== 1'b1 && n < 1000);
      check(64'(n), 64'(e));
   endtask : gap

   ////////////////////////////////////////////////////////////////////////////////
   int          gaps[3] = '{8, 32, 256};
   logic [11:0] fhi;
   logic [12:0] flo;

   initial begin
      #300_000;
      n_errors++;
      summarize();
   end

   initial begin
      void'($urandom(96));
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      apb(1'b0, APB_CTRL, 32'h0, 32'hFFFF_FFFF, CTRL_RESET, 1'b0);
      for (int i = 0; i < NUM_LATCH; i++) begin
         w[i] = {$urandom()} & 32'hFFFF_FFF8 | 32'(i);
         i_host.send(w[i]);
      end
      for (int i = 0; i < NUM_LATCH; i++)
         apb(1'b0, 8'(APB_LATCH0 + 4 * i), 32'h0, 32'hFFFF_FFFF, w[i], 1'b0);
      flo = 13'($urandom());
      fhi = 12'($urandom());
      shadow(4'hA, 5'h02, 1'b0, 1'b0, flo);
      apb(1'b0, APB_REFCFG, 32'h0, 32'h0000_0FFF, 32'h0, 1'b0);
      check(64'(cpCurrent), 64'h0);
      i_host.send({1'b0, OBS_HIGH, 12'h017, fhi, 3'h0});
      apb(1'b0, APB_REFCFG, 32'h0, 32'h0000_FFFF, 32'h0000_1A02, 1'b0);
      apb(1'b0, APB_INTFRAC, 32'h0, 32'hFFFF_FFFF, {7'h17, fhi, flo}, 1'b0);
      check(64'(cpCurrent), 64'hA);
      check(64'(observation_output), 64'h1);
      gap(1'b0, 16);
      // A zero fraction leaves no carry, so the feedback period is exactly the integer ratio, raised to the minimum of 23 where 10 is sent.
      for (int i = 0; i < 3; i++) begin
         shadow(4'h3, (i == 2) ? 5'h00 : 5'h02, i == 0, i == 1, 13'h0);
         i_host.send({1'b0, (i == 0) ? OBS_POWERED : OBS_LOW, (i == 1) ? 12'h017 : 12'h00A, 15'h0});
         gap(1'b0, gaps[i]);
         gap(1'b1, 92);
         if (i == 0) check(64'(observation_output), 64'h1);
      end
      gap(1'b1, 92);
      check(64'(observation_output), 64'h0);
      chipEnable <= 1'b0;
      repeat (8) @(posedge mclk);
      check(64'(cpEnable), 64'h0);
      apb(1'b0, APB_STATUS, 32'h0, 32'h0000_0007, 32'h0, 1'b0);
      chipEnable <= 1'b1;
      repeat (8) @(posedge mclk);
      check(64'(cpEnable), 64'h1);
      apb(1'b1, APB_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
      repeat (4) @(posedge mclk);
      check(64'(cpEnable), 64'h0);
      apb(1'b0, APB_CTRL, 32'h0, 32'hFFFF_FFFF, 32'h1, 1'b0);
      apb(1'b1, APB_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
      apb(1'b1, APB_STATUS, 32'h7, 32'hFFFF_FFFF, 32'h0, 1'b1);
      apb(1'b0, 8'h80, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
      apb(1'b0, 8'h22, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
      repeat (4) @(posedge mclk);
      summarize();
   end
endmodule : tb

`default_nettype wire
